// *** rtl/sac_pkg.sv ***
// Shared constants and types for the converter control block
`default_nettype none
package sac_pkg;

  // Core clock period and cycle arithmetic
  localparam int CLK_PERIOD_NS = 10;

  // Acquire phase, typical figure, rounded up to whole cycles
  localparam int ACQ_TIME_NS   = 160;
  localparam int ACQ_CYCLES    = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Least strobe-to-serial-clock setup, rounded up to whole cycles
  localparam int SETUP_TIME_NS = 70;
  localparam int SETUP_CYCLES  = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Result word layout
  localparam int RESULT_BITS   = 12;
  localparam int MSB_INDEX     = RESULT_BITS - 1;
  localparam int LAST_EDGE     = RESULT_BITS + 1;
  localparam int CNT_W         = 8;
  localparam int EDGE_W        = 4;

  // Values after reset and at conversion start
  localparam logic [RESULT_BITS-1:0] SAR_CLEAR = 12'h000;
  localparam logic [RESULT_BITS-1:0] MSB_TRIAL = 12'h800;

  // Synchroniser lane positions
  localparam int LANE_SCLK   = 0;
  localparam int LANE_STROBE = 1;
  localparam int LANE_COMP   = 2;
  localparam int LANE_NEGSUP = 3;
  localparam int LANE_REFLOW = 4;
  localparam int LANE_REFOK  = 5;
  localparam int LANES       = 6;

  // Conversion sequencer states, Gray from idle to acquire to convert
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_ACQUIRE = 2'b01,
    ST_CONVERT = 2'b11
  } sac_state_t;

endpackage : sac_pkg
`default_nettype wire

// *** rtl/sac_sync.sv ***
// Two-stage synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none
module sac_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  ////////////////////////////////////////////////////////////////////////////
  // One pair of flip-flops per lane; the first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : gLane
      logic stage1;
      always_ff @(posedge core_clk) begin
        if (reset) begin
          stage1     <= 1'b0;
          syncOut[i] <= 1'b0;
        end else begin
          stage1     <= asyncIn[i];
          syncOut[i] <= stage1;
        end
      end
    end
  endgenerate

endmodule : sac_sync
`default_nettype wire

// *** rtl/sac_conversion_start_strobe_ctrl.sv ***
// Successive-approximation conversion sequencer with serial result output
`timescale 1ns/1ns
`default_nettype none
module sac_conversion_start_strobe_ctrl (
  // Clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            reset,
  // Host serial link pins
  input  wire logic                            serialClk,
  input  wire logic                            conversionStartStrobe,
  output logic                                 dataOut,
  output logic                                 dataOutEn,
  // Analog front end
  input  wire logic                            comparatorHigh,
  output logic [sac_pkg::RESULT_BITS-1:0]      successiveApproxRegister,
  output logic                                 sampleEnable,
  // Supply and reference sensing
  input  wire logic                            negSupplyBelowGround,
  input  wire logic                            referenceBelowLimit,
  input  wire logic                            referenceSettled,
  // Status
  output logic                                 busy,
  output logic                                 bipolarMode
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [sac_pkg::LANES-1:0] pinRaw;
  logic [sac_pkg::LANES-1:0] pinSync;

  assign pinRaw[sac_pkg::LANE_SCLK]   = serialClk;
  assign pinRaw[sac_pkg::LANE_STROBE] = conversionStartStrobe;
  assign pinRaw[sac_pkg::LANE_COMP]   = comparatorHigh;
  assign pinRaw[sac_pkg::LANE_NEGSUP] = negSupplyBelowGround;
  assign pinRaw[sac_pkg::LANE_REFLOW] = referenceBelowLimit;
  assign pinRaw[sac_pkg::LANE_REFOK]  = referenceSettled;

  sac_sync #(
    .WIDTH (sac_pkg::LANES)
  ) uSync (
    .core_clk (core_clk),
    .reset    (reset),
    .asyncIn  (pinRaw),
    .syncOut  (pinSync)
  );

  // Named views of the synchronised lanes
  wire sclkS     = pinSync[sac_pkg::LANE_SCLK];
  wire strobeS   = pinSync[sac_pkg::LANE_STROBE];
  wire compS     = pinSync[sac_pkg::LANE_COMP];
  wire negSupS   = pinSync[sac_pkg::LANE_NEGSUP];
  wire refLowS   = pinSync[sac_pkg::LANE_REFLOW];
  wire refOkS    = pinSync[sac_pkg::LANE_REFOK];

  ////////////////////////////////////////////////////////////////////////////
  // State

  sac_pkg::sac_state_t              state;
  logic                             sclkPrev;
  logic                             strobePrev;
  logic [sac_pkg::CNT_W-1:0]        acqCount;
  logic [sac_pkg::CNT_W-1:0]        setupCount;
  logic [sac_pkg::EDGE_W-1:0]       edgeCount;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and decode

  wire sclkRise   = sclkS & ~sclkPrev;
  wire strobeRise = strobeS & ~strobePrev;
  wire isIdle     = (state == sac_pkg::ST_IDLE);
  wire isAcquire  = (state == sac_pkg::ST_ACQUIRE);
  wire isConvert  = (state == sac_pkg::ST_CONVERT);
  wire active     = isAcquire | isConvert;

  // edges while busy are not looked at
  wire startConv  = isIdle & strobeRise;

  // acquire ends after the hold count
  wire acqDone    = isAcquire & (acqCount == '0);

  // a clock edge inside the setup window is skipped
  wire setupMet   = (setupCount == '0);
  wire validEdge  = active & sclkRise & setupMet;

  // Edge roles: flag edge, decision edges, release edge
  wire firstEdge  = validEdge & (edgeCount == '0);
  wire lastEdge   = validEdge & isConvert & (edgeCount == sac_pkg::EDGE_W'(sac_pkg::LAST_EDGE));
  // Decisions need the compare phase; an early edge while sampling is dropped
  wire decide     = validEdge & isConvert & (edgeCount != '0) & ~lastEdge;

  ////////////////////////////////////////////////////////////////////////////
  // Approximation step

  // bit under test walks from the top down
  wire [sac_pkg::EDGE_W-1:0]      bitIdx    = sac_pkg::EDGE_W'(sac_pkg::RESULT_BITS) - edgeCount;
  wire [sac_pkg::RESULT_BITS-1:0] bitMask   = sac_pkg::RESULT_BITS'(1) << bitIdx;
  wire [sac_pkg::RESULT_BITS-1:0] trialMask = bitMask >> 1;
  wire [sac_pkg::RESULT_BITS-1:0] keepMask  = compS ? bitMask : sac_pkg::SAR_CLEAR;
  // keep or drop this bit and raise the next trial in one step
  wire [sac_pkg::RESULT_BITS-1:0] next_sar  =
    (successiveApproxRegister & ~bitMask) | keepMask | trialMask;

  // unipolar bits go out as decided
  // bipolar inverts the sign bit to give two's complement
  wire signBit    = (bitIdx == sac_pkg::EDGE_W'(sac_pkg::MSB_INDEX));
  wire codedBit   = compS ^ (bipolarMode & signBit);

  // ready flag is zero when the reference is low or unsettled
  wire readyFlag  = refOkS & ~refLowS;

  ////////////////////////////////////////////////////////////////////////////
  // Edge history registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sclkPrev   <= 1'b0;
      strobePrev <= 1'b0;
    end else begin
      sclkPrev   <= sclkS;
      strobePrev <= strobeS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= sac_pkg::ST_IDLE;
    end else begin
      case (state)
        sac_pkg::ST_IDLE: begin
          if (startConv) begin
            state <= sac_pkg::ST_ACQUIRE;
          end
        end
        sac_pkg::ST_ACQUIRE: begin
          if (acqDone) begin
            state <= sac_pkg::ST_CONVERT;
          end
        end
        sac_pkg::ST_CONVERT: begin
          // only the release edge returns to idle
          if (lastEdge) begin
            state <= sac_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= sac_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acquire and setup timers, loaded at start, count down to zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      acqCount   <= '0;
      setupCount <= '0;
    end else if (startConv) begin
      acqCount   <= sac_pkg::CNT_W'(sac_pkg::ACQ_CYCLES - 1);
      setupCount <= sac_pkg::CNT_W'(sac_pkg::SETUP_CYCLES - 1);
    end else begin
      if (acqCount != '0) begin
        acqCount <= acqCount - 1'b1;
      end
      if (setupCount != '0) begin
        setupCount <= setupCount - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial edge counter
  always_ff @(posedge core_clk) begin
    if (reset || startConv) begin
      edgeCount <= '0;
    end else if (firstEdge || decide) begin
      edgeCount <= edgeCount + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Approximation register; it also drives the DAC
  always_ff @(posedge core_clk) begin
    if (reset) begin
      successiveApproxRegister <= sac_pkg::SAR_CLEAR;
    end else if (startConv) begin
      successiveApproxRegister <= sac_pkg::SAR_CLEAR;
    end else if (acqDone) begin
      // first trial is the top bit
      successiveApproxRegister <= sac_pkg::MSB_TRIAL;
    end else if (decide) begin
      successiveApproxRegister <= next_sar;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample switch, busy and mode latch
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sampleEnable <= 1'b0;
      busy         <= 1'b0;
      bipolarMode  <= 1'b0;
    end else begin
      // sample from start until the hold count runs out
      sampleEnable <= startConv | (sampleEnable & ~acqDone);
      busy         <= startConv | (busy & ~lastEdge);
      // mode taken once per conversion so coding is stable mid-word
      if (startConv) begin
        bipolarMode <= negSupS;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial data pin, updated only on accepted clock edges
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dataOut   <= 1'b0;
      dataOutEn <= 1'b0;
    end else if (firstEdge) begin
      // output moves on a rising clock edge
      dataOut   <= readyFlag;
      dataOutEn <= 1'b1;
    end else if (decide) begin
      // each decided bit leaves as soon as it is known
      dataOut   <= codedBit;
      dataOutEn <= 1'b1;
    end else if (lastEdge) begin
      dataOut   <= 1'b0;
      dataOutEn <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Helper: length of the sampling window
  logic [sac_pkg::CNT_W-1:0] acqHigh;
  always_ff @(posedge core_clk) begin
    if (reset || !sampleEnable) begin
      acqHigh <= '0;
    end else begin
      acqHigh <= acqHigh + 1'b1;
    end
  end

  sequence seqStartClear;
    (state == sac_pkg::ST_ACQUIRE) && (successiveApproxRegister == sac_pkg::SAR_CLEAR) && sampleEnable;
  endsequence

  sequence seqFlagOut;
    dataOutEn && (dataOut == $past(readyFlag));
  endsequence

  a_start_begins: assert property (@(posedge core_clk) disable iff (reset)
    (isIdle && strobeRise) |=> busy && (state == sac_pkg::ST_ACQUIRE))
    else $error("start edge did not begin a conversion");

  a_start_clears: assert property (@(posedge core_clk) disable iff (reset)
    startConv |=> seqStartClear)
    else $error("register not cleared at start");

  a_no_restart: assert property (@(posedge core_clk) disable iff (reset)
    (isConvert && strobeRise && !lastEdge) |=> isConvert && (setupCount == $past(setupCount)))
    else $error("conversion restarted while busy");

  a_msb_trial: assert property (@(posedge core_clk) disable iff (reset)
    acqDone |=> (successiveApproxRegister == sac_pkg::MSB_TRIAL) && !sampleEnable)
    else $error("first trial is not the top bit");

  a_acq_length: assert property (@(posedge core_clk) disable iff (reset)
    $fell(sampleEnable) |-> (acqHigh == sac_pkg::CNT_W'(sac_pkg::ACQ_CYCLES)))
    else $error("acquire phase has wrong length");

  a_word_end: assert property (@(posedge core_clk) disable iff (reset)
    lastEdge |=> !dataOutEn && isIdle && !busy)
    else $error("word did not end on release edge");

  a_mode_latch: assert property (@(posedge core_clk) disable iff (reset)
    startConv |=> (bipolarMode == $past(negSupS)) ##1 (bipolarMode == $past(bipolarMode)))
    else $error("mode not taken at start");

  a_flag_first: assert property (@(posedge core_clk) disable iff (reset)
    firstEdge |=> seqFlagOut)
    else $error("ready flag not sent first");

  a_ref_low: assert property (@(posedge core_clk) disable iff (reset)
    (firstEdge && refLowS) |=> !dataOut)
    else $error("flag not forced low by reference");

  a_unipolar_bits: assert property (@(posedge core_clk) disable iff (reset)
    (decide && !bipolarMode) |=> (dataOut == $past(compS)))
    else $error("unipolar bit not straight binary");

  a_bipolar_sign: assert property (@(posedge core_clk) disable iff (reset)
    (decide && bipolarMode && signBit) |=> (dataOut == !$past(compS)))
    else $error("bipolar sign bit not inverted");

  a_out_on_edge: assert property (@(posedge core_clk) disable iff (reset)
    ($changed(dataOut) || $changed(dataOutEn)) |-> $past(validEdge))
    else $error("data pin moved without a clock edge");

  a_setup_skip: assert property (@(posedge core_clk) disable iff (reset)
    (active && sclkRise && !setupMet) |=> $stable(edgeCount) && $stable(dataOutEn))
    else $error("edge inside setup window was used");

  a_one_per_edge: assert property (@(posedge core_clk) disable iff (reset)
    decide |=> (edgeCount == $past(edgeCount) + 1'b1) ##1 (edgeCount == $past(edgeCount)))
    else $error("decision count off per clock");

endmodule : sac_conversion_start_strobe_ctrl
`default_nettype wire

// *** sim/sac_host_model.sv ***
// Host serial port model: start strobe, serial clock and word capture
`timescale 1ns/1ns
`default_nettype none
module sac_host_model (
  // Clock
  input  wire logic   core_clk,
  // Device pins
  input  wire logic   dataOut,
  input  wire logic   dataOutEn,
  output logic        serialClk,
  output logic        conversionStartStrobe,
  // Captured word
  output logic [12:0] word,
  output logic [4:0]  enCount,
  output logic        wordValid
);
  //////////////////////////////////////////////////////////////////////////////
  // Pins idle low; the serial clock stands still outside frames
  initial begin
    serialClk = 1'b0;
    conversionStartStrobe = 1'b0;
    word = 13'h0000;
    enCount = 5'h00;
    wordValid = 1'b0;
  end

  // One conversion; lead is core cycles from strobe rise to first clock rise
  // rising strobe opens the word
  task automatic convert(input int lead, input bit extra);
    int n;
    int m;
    int rises;
    // A short lead costs one extra clock, so the host gives one more rise
    rises = (lead < sac_pkg::SETUP_CYCLES) ? 15 : 14;
    @(posedge core_clk);
    conversionStartStrobe <= 1'b1;
    enCount <= 5'h00;
    for (n = 1; n <= lead + 20 * rises - 10; n++) begin
      @(posedge core_clk);
      m = n - lead;
      if (n == 5) conversionStartStrobe <= 1'b0;
      // Stray strobe mid-word, held high until the word is out
      if (extra && n == 60) conversionStartStrobe <= 1'b1;
      // capture and launch on rising clock
      if (m >= 0 && m % 20 == 0) begin
        serialClk <= 1'b1;
        word <= {word[11:0], dataOut};
        enCount <= enCount + {4'h0, dataOutEn};
      end
      if (m >= 0 && m % 20 == 10) serialClk <= 1'b0;
    end
    conversionStartStrobe <= 1'b0;
    wordValid <= 1'b1;
    @(posedge core_clk);
    wordValid <= 1'b0;
  endtask : convert
endmodule : sac_host_model
`default_nettype wire

// *** sim/sac_conversion_start_strobe_ctrl_tb.sv ***
// Self-checking testbench for the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module sac_conversion_start_strobe_ctrl_tb;
  logic        core_clk;
  logic        reset;
  logic        serialClk;
  logic        conversionStartStrobe;
  logic        dataOut;
  logic        dataOutEn;
  logic        comparatorHigh;
  logic [11:0] successiveApproxRegister;
  logic        sampleEnable;
  logic        negSupplyBelowGround;
  logic        referenceBelowLimit;
  logic        referenceSettled;
  logic        busy;
  logic        bipolarMode;
  logic [12:0] word;
  logic [4:0]  enCount;
  logic        wordValid;
  logic [11:0] level;
  logic        prevSe = 1'b0;
  int          acqCount = 0;
  int          failures;
  int          nTests;
  int          cycles;
  logic [12:0] expWord[$];
  logic [11:0] expSar[$];
  logic        expMode[$];

  //////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  always #5 core_clk = ~core_clk;

  sac_conversion_start_strobe_ctrl dut (
    .core_clk(core_clk), .reset(reset), .serialClk(serialClk),
    .conversionStartStrobe(conversionStartStrobe), .dataOut(dataOut), .dataOutEn(dataOutEn),
    .comparatorHigh(comparatorHigh), .successiveApproxRegister(successiveApproxRegister),
    .sampleEnable(sampleEnable), .negSupplyBelowGround(negSupplyBelowGround),
    .referenceBelowLimit(referenceBelowLimit), .referenceSettled(referenceSettled),
    .busy(busy), .bipolarMode(bipolarMode)
  );

  sac_host_model host (
    .core_clk(core_clk), .dataOut(dataOut), .dataOutEn(dataOutEn), .serialClk(serialClk),
    .conversionStartStrobe(conversionStartStrobe), .word(word), .enCount(enCount),
    .wordValid(wordValid)
  );

  // Ideal comparator: high while the held input is at or above the trial code
  always @(posedge core_clk) comparatorHigh <= (level >= successiveApproxRegister);

  //////////////////////////////////////////////////////////////////////////////
  // Comparison and closing
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  // A hang is cut short well past eight words of about 300 cycles each
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      give_verdict();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Monitor: acquire window checks, then the oldest note against each word
  always @(posedge core_clk) begin
    if (sampleEnable && !prevSe) begin
      acqCount = 1;
      check("sar cleared", {4'h0, successiveApproxRegister}, 16'h0000);
      check("busy at start", {15'h0000, busy}, 16'h0001);
    end else if (sampleEnable) begin
      acqCount++;
    end else if (prevSe) begin
      // acquire length, then MSB trial first
      check("acquire cycles", acqCount[15:0], 16'h0010);
      check("first trial", {4'h0, successiveApproxRegister}, 16'h0800);
      check("mode", {15'h0000, bipolarMode}, {15'h0000, expMode.pop_front()});
    end
    if (wordValid) begin
      check("serial word", {3'h0, word}, {3'h0, expWord.pop_front()});
      check("final sar", {4'h0, successiveApproxRegister}, {4'h0, expSar.pop_front()});
      check("driven bits", {11'h000, enCount}, 16'h000d);
      check("released pin", {14'h0000, dataOutEn, busy}, 16'h0000);
    end
    prevSe = sampleEnable;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Driver: codes, modes, reference states, short lead and stray strobe
  initial begin : driver
    int i;
    int k;
    logic [31:0] r;
    logic [11:0] lvl;
    logic        bip;
    core_clk = 1'b0;
    reset = 1'b1;
    level = 12'h000;
    negSupplyBelowGround = 1'b0;
    referenceBelowLimit = 1'b0;
    referenceSettled = 1'b1;
    failures = 0;
    nTests = 0;
    cycles = 0;
    void'($urandom(32'h3057b793));
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
    check("idle enable", {15'h0000, dataOutEn}, 16'h0000);
    check("idle busy", {15'h0000, busy}, 16'h0000);
    for (i = 0; i < 8; i++) begin
      r = $urandom;
      lvl = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : r[11:0];
      bip = i[0];
      level <= lvl;
      negSupplyBelowGround <= bip;
      referenceBelowLimit <= (i == 3);
      referenceSettled <= (i != 5);
      repeat (5) @(posedge core_clk);
      // Bipolar words are the straight code with the top bit inverted
      expWord.push_back({(i != 3) && (i != 5), bip ? {~lvl[11], lvl[10:0]} : lvl});
      expSar.push_back(lvl);
      expMode.push_back(bip);
      // short lead in runs 2 and 6, stray strobe in run 4
      host.convert((i == 2 || i == 6) ? 3 : 12, i == 4);
      for (k = 0; k < 50 && busy !== 1'b0; k++) @(posedge core_clk);
      repeat (5) @(posedge core_clk);
    end
    give_verdict();
  end
endmodule : sac_conversion_start_strobe_ctrl_tb
`default_nettype wire
